// File: inc/smc_consts.vh
// Sleep mode controller constants: mode codes, wake timing.
// Assumes inclusion by the controller files only.
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
`define SMC_MODE_IDLE     3'h0
`define SMC_MODE_NRM      3'h1
`define SMC_MODE_PDOWN    3'h2
`define SMC_MODE_PSAVE    3'h3
`define SMC_MODE_STBY     3'h6
`define SMC_MODE_XSTBY    3'h7
`define SMC_WAKE_HALT_CYC 4'h4
`define SMC_STBY_WAKE_CYC 4'h6
`define SMC_STBY_START    4'h2
`define SMC_START_DEFAULT 16'h0006
`endif

// File: hw/smc_clk_gate.v
// Glitch-free clock gate: enable captured on the falling clock edge.
// Assumes clk_in is the free-running domain clock.
`default_nettype none
module smc_clk_gate (
   input  wire clk_in,
   input  wire en_in,
   output wire gclk_out
);
   reg en_q;
   // Enable only changes while the clock is low, so no pulse is ever cut
   always @(negedge clk_in) begin
      en_q <= en_in;
   end
   assign gclk_out = clk_in & en_q;
endmodule
`default_nettype wire

// File: hw/smc_sleep_ctrl.v
// Sleep mode controller: mode decode, clock gating, wake sequencing.
// Assumes core pulses sleep_instr_in; level inputs are from pins.
`include "smc_consts.vh"
`default_nettype none
module smc_sleep_ctrl #(
   parameter [15:0] START_CYC = `SMC_START_DEFAULT
) (
   input  wire       clock_in,
   input  wire       arst_n_in,
   input  wire       sleep_instr_in,
   input  wire       sleep_enable_bit_in,
   input  wire [2:0] sleep_mode_field_in,
   input  wire       crystal_selected_in,
   input  wire       timer2_external_clock_flag_in,
   input  wire       comparator_power_off_bit_in,
   input  wire       converter_enable_in,
   input  wire       ext_irq_zero_in,
   input  wire       ext_irq_zero_level_in,
   input  wire       ext_irq_one_in,
   input  wire       ext_irq_one_level_in,
   input  wire       ext_irq_two_in,
   input  wire       twi_match_irq_in,
   input  wire       timer2_irq_in,
   input  wire       spm_ready_irq_in,
   input  wire       converter_irq_in,
   input  wire       comparator_irq_in,
   input  wire       other_io_irq_in,
   input  wire       any_reset_in,
   output wire       core_clk_out,
   output wire       flash_clk_out,
   output wire       io_clk_out,
   output wire       conv_clk_out,
   output wire       rtc_timer_clock_domain_out,
   output reg        main_osc_en_out,
   output reg        timer_osc_en_out,
   output reg        core_halt_out,
   output reg        sleeping_out,
   output reg        wake_irq_out,
   output reg        reset_vector_out,
   output reg        conv_start_out,
   output reg        comparator_off_out
);
   // ------------------------------------------------------------
   // States and pin synchronisers
   // ------------------------------------------------------------
   localparam [3:0] ST_RUN = 4'h1, ST_SLEEP = 4'h2, ST_START = 4'h4, ST_HALT = 4'h8;
   localparam NS = 13;
   wire [NS-1:0] raw = {any_reset_in, ext_irq_zero_in, ext_irq_zero_level_in,
                        ext_irq_one_in, ext_irq_one_level_in, ext_irq_two_in,
                        twi_match_irq_in, timer2_irq_in, spm_ready_irq_in,
                        converter_irq_in, comparator_irq_in, other_io_irq_in,
                        crystal_selected_in};
   reg  [NS-1:0] s1_q;
   reg  [NS-1:0] s2_q;
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1_q <= {NS{1'b0}};
         s2_q <= {NS{1'b0}};
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   wire rst_s = s2_q[12];
   wire i0 = s2_q[11];
   wire i0_lvl = s2_q[10];
   wire i1 = s2_q[9];
   wire i1_lvl = s2_q[8];
   wire i2 = s2_q[7];
   wire two_wire_interface = s2_q[6];
   wire t2 = s2_q[5];
   wire spm = s2_q[4];
   wire cv = s2_q[3];
   wire cmp = s2_q[2];
   wire oio = s2_q[1];
   wire xtal = s2_q[0];

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   reg  [3:0]  st_q;
   reg  [3:0]  st_d;
   reg  [2:0]  mode_q;
   reg  [15:0] cnt_q;
   reg  [15:0] cnt_d;

   // Codes 100/101, or standby without a crystal, do not sleep
   function mode_valid;
      input [2:0] m;
      input       x;
      begin
         case (m)
            `SMC_MODE_IDLE, `SMC_MODE_NRM, `SMC_MODE_PDOWN,
            `SMC_MODE_PSAVE: mode_valid = 1'b1;
            `SMC_MODE_STBY, `SMC_MODE_XSTBY: mode_valid = x;
            default: mode_valid = 1'b0;
         endcase
      end
   endfunction

   wire m_idle = mode_q == `SMC_MODE_IDLE;
   wire m_nrm = mode_q == `SMC_MODE_NRM;
   wire m_psave = mode_q == `SMC_MODE_PSAVE;
   wire m_stby = mode_q == `SMC_MODE_STBY;
   wire m_xstby = mode_q == `SMC_MODE_XSTBY;
   wire asleep = st_q == ST_SLEEP;
   wire t2_ok = timer2_external_clock_flag_in;

   // ------------------------------------------------------------
   // Wake source qualification
   // ------------------------------------------------------------
   wire ext_lim = i2 | (i0 & i0_lvl) | (i1 & i1_lvl);
   wire ext_any = i2 | i0 | i1;
   wire cmp_ok = cmp & ~comparator_power_off_bit_in;
   reg  wake;
   always @* begin
      case (mode_q)
         `SMC_MODE_IDLE: wake = ext_any | two_wire_interface | t2 | spm | cv | cmp_ok | oio;
         `SMC_MODE_NRM: wake = ext_lim | two_wire_interface | t2 | spm | cv;
         `SMC_MODE_PSAVE,
         `SMC_MODE_XSTBY: wake = ext_lim | two_wire_interface | (t2 & t2_ok);
         default: wake = ext_lim | two_wire_interface;
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   wire go = sleep_instr_in & sleep_enable_bit_in &
             mode_valid(sleep_mode_field_in, xtal);
   wire fast = m_idle | m_nrm | m_stby | m_xstby;
   // Fast wake: 2 start cycles + 4 halt = six total from standby
   wire [15:0] start_len = (m_stby | m_xstby) ? {12'h000, `SMC_STBY_START} :
                           (m_idle | m_nrm) ? 16'h0001 : START_CYC;
   always @* begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_RUN: begin
            if (go) begin
               st_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               st_d = ST_START;
               cnt_d = start_len;
            end
         end
         ST_START: begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001) begin
               st_d = ST_HALT;
               cnt_d = {12'h000, `SMC_WAKE_HALT_CYC};
            end
         end
         ST_HALT: begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001) begin
               st_d = ST_RUN;
            end
         end
         default: st_d = ST_RUN;
      endcase
      if (rst_s && st_q != ST_RUN) begin
         st_d = ST_RUN;
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= ST_RUN;
         cnt_q <= 16'h0000;
         mode_q <= `SMC_MODE_IDLE;
         wake_irq_out <= 1'b0;
         reset_vector_out <= 1'b0;
         conv_start_out <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         if (st_q == ST_RUN && go) begin
            mode_q <= sleep_mode_field_in;
         end
         // Core services the interrupt, then returns past the instruction
         wake_irq_out <= st_q == ST_HALT && st_d == ST_RUN && !rst_s;
         reset_vector_out <= rst_s && st_q != ST_RUN;
         conv_start_out <= st_q == ST_RUN && go && converter_enable_in &&
                           (sleep_mode_field_in == `SMC_MODE_IDLE ||
                            sleep_mode_field_in == `SMC_MODE_NRM);
      end
   end

   // ------------------------------------------------------------
   // Clock domain enables; memories never lose power
   // ------------------------------------------------------------
   wire osc_on = st_q != ST_SLEEP;
   reg  en_core, en_io, en_conv, en_asy;
   always @* begin
      en_core = ~asleep;
      en_io = ~asleep | m_idle;
      en_conv = ~asleep | m_idle | m_nrm;
      en_asy = ~asleep | m_idle | m_nrm | ((m_psave | m_xstby) & t2_ok);
   end
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         main_osc_en_out <= 1'b1;
         timer_osc_en_out <= 1'b0;
         core_halt_out <= 1'b0;
         sleeping_out <= 1'b0;
         comparator_off_out <= 1'b0;
      end else begin
         main_osc_en_out <= osc_on | fast;
         timer_osc_en_out <= t2_ok & (~asleep | ~(mode_q == `SMC_MODE_PDOWN |
                             m_stby));
         core_halt_out <= st_d != ST_RUN;
         sleeping_out <= st_d == ST_SLEEP;
         comparator_off_out <= comparator_power_off_bit_in | (st_d == ST_SLEEP &
                               ~(sleep_mode_field_in == `SMC_MODE_IDLE) & ~m_idle);
      end
   end
   smc_clk_gate u_core (.clk_in(clock_in), .en_in(en_core), .gclk_out(core_clk_out));
   smc_clk_gate u_flash (.clk_in(clock_in), .en_in(en_core), .gclk_out(flash_clk_out));
   smc_clk_gate u_io (.clk_in(clock_in), .en_in(en_io), .gclk_out(io_clk_out));
   smc_clk_gate u_conv (.clk_in(clock_in), .en_in(en_conv), .gclk_out(conv_clk_out));
   smc_clk_gate u_asy (.clk_in(clock_in), .en_in(en_asy),
                       .gclk_out(rtc_timer_clock_domain_out));
endmodule
`default_nettype wire

// File: tb/smc_sleep_ctrl_monitor.sv
// Checker: port assertions of the sleep controller.
// Assumes a bind onto smc_sleep_ctrl.
`default_nettype none
module smc_sleep_monitor (
   input wire logic       clock_in,
   input wire logic       arst_n_in,
   input wire logic       sleep_instr_in,
   input wire logic       sleep_enable_bit_in,
   input wire logic [2:0] sleep_mode_field_in,
   input wire logic       timer2_external_clock_flag_in,
   input wire logic       converter_enable_in,
   input wire logic       main_osc_en_out,
   input wire logic       timer_osc_en_out,
   input wire logic       core_halt_out,
   input wire logic       sleeping_out,
   input wire logic       wake_irq_out,
   input wire logic       reset_vector_out,
   input wire logic       conv_start_out,
   input wire logic       comparator_off_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   a_sleep_enable: assert property ($rose(sleeping_out) |->
      $past(sleep_instr_in && sleep_enable_bit_in)) else $error("sleep without enable");
   a_sleep_halts: assert property (sleeping_out |-> core_halt_out)
      else $error("core runs in sleep");
   a_bad_mode: assert property (sleep_instr_in && !sleeping_out &&
      sleep_mode_field_in[2:1] == 2'b10 |=> !sleeping_out) else $error("bad mode slept");
   a_wake_halt: assert property (wake_irq_out |->
      !core_halt_out && $past(core_halt_out, 4)) else $error("halt span short");
   a_conv_start: assert property (conv_start_out |-> sleeping_out &&
      converter_enable_in && sleep_mode_field_in[2:1] == 2'b00) else $error("stray start");
   a_pdown_osc: assert property (sleeping_out && $past(sleeping_out) &&
      sleep_mode_field_in == 3'h2 |-> !main_osc_en_out && !timer_osc_en_out)
      else $error("osc on in power-down");
   a_stby_osc: assert property (sleeping_out &&
      sleep_mode_field_in[2:1] == 2'b11 |-> main_osc_en_out) else $error("osc off");
   a_timer_osc: assert property (timer_osc_en_out |->
      $past(timer2_external_clock_flag_in)) else $error("timer osc without flag");
   a_comp_off: assert property (sleeping_out && $past(sleeping_out) &&
      sleep_mode_field_in != 3'h0 |-> comparator_off_out) else $error("comparator on");
   a_reset_vec: assert property ($rose(reset_vector_out) |->
      $past(core_halt_out)) else $error("reset vector while running");
endmodule
`default_nettype wire

// File: tb/smc_core_model.sv
// Core model: issues the sleep instruction on request.
// Assumes go_in is driven off the falling edge.
`default_nettype none
module smc_core_model (
   input  wire logic go_in,
   input  wire logic core_halt_in,
   output wire logic sleep_instr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // A halted core executes nothing, so it cannot repeat the instruction
   assign sleep_instr_out = go_in && !core_halt_in;
endmodule
`default_nettype wire

// File: tb/tb_smc_sleep_ctrl.sv
// Testbench: mode table, wake sources, reset exit.
// Assumes the controller and core model files.
`default_nettype none
module tb_smc_sleep_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in = 0;
   logic        arst_n_in = 0;
   logic        go = 0;
   logic        sen = 0;
   logic        rst = 0;
   logic [2:0]  mode = 3'h0;
   logic [3:0]  cfg = 4'h0;
   logic [10:0] irq = 11'h000;
   wire logic   sinstr, halt, sleeping, wake, rvec, cstart, cclk, iclk;
   integer      ccnt = 0;
   integer      icnt = 0;
   integer      err_count = 0;
   integer      samples_checked = 0;
   always #5 clock_in = ~clock_in;
   // Pulse counters on the gated domains show whether a clock really stopped
   always @(posedge cclk) ccnt = ccnt + 1;
   always @(posedge iclk) icnt = icnt + 1;
   smc_core_model core (.go_in(go), .core_halt_in(halt), .sleep_instr_out(sinstr));
   smc_sleep_ctrl #(.START_CYC(16'h0002)) dut (.clock_in, .arst_n_in,
      .sleep_instr_in(sinstr), .sleep_enable_bit_in(sen), .sleep_mode_field_in(mode),
      .crystal_selected_in(cfg[3]), .timer2_external_clock_flag_in(cfg[2]),
      .comparator_power_off_bit_in(cfg[1]), .converter_enable_in(cfg[0]),
      .ext_irq_two_in(irq[10]), .ext_irq_zero_in(irq[9]), .ext_irq_zero_level_in(irq[8]),
      .ext_irq_one_in(irq[7]), .ext_irq_one_level_in(irq[6]), .twi_match_irq_in(irq[5]),
      .timer2_irq_in(irq[4]), .spm_ready_irq_in(irq[3]), .converter_irq_in(irq[2]),
      .comparator_irq_in(irq[1]), .other_io_irq_in(irq[0]), .any_reset_in(rst),
      .core_clk_out(cclk), .flash_clk_out(), .io_clk_out(iclk), .conv_clk_out(),
      .rtc_timer_clock_domain_out(), .main_osc_en_out(), .timer_osc_en_out(),
      .core_halt_out(halt), .sleeping_out(sleeping), .wake_irq_out(wake),
      .reset_vector_out(rvec), .conv_start_out(cstart), .comparator_off_out());
   task chk(input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
      end
   endtask
   task results;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Sleep in mode m, raise sources s, expect sleep es and wake ew
   task run(input [2:0] m, input e, input [3:0] c, input [10:0] s, input es, input ew);
      integer n, c_base, i_base;
      logic cs, rv;
      begin
         mode = m;
         sen = e;
         cfg = c;
         cs = 0;
         rv = 0;
         n = 0;
         repeat (3) @(negedge clock_in);
         go = 1;
         repeat (3) begin
            @(negedge clock_in);
            go = 0;
            cs = cs | cstart;
         end
         chk(sleeping, es);
         chk(cs, es && c[0] && m[2:1] == 2'b00);
         c_base = ccnt;
         i_base = icnt;
         repeat (4) @(negedge clock_in);
         chk(ccnt == c_base, es);
         chk(icnt == i_base, es && m != 3'h0);
         irq = s;
         while (wake !== 1'b1 && n < 40) begin
            @(negedge clock_in);
            n++;
         end
         irq = 11'h000;
         chk(n < 40, ew);
         if (ew) chk(n >= 6 && halt === 1'b0, 1'b1);
         // Two synchroniser stages and the sampling edge come before the six
         if (m[2]) chk(n <= 9, ew);
         if (es && !ew) begin
            rst = 1;
            repeat (4) begin
               @(negedge clock_in);
               rv = rv | rvec;
            end
            rst = 0;
            chk(rv && !sleeping, 1'b1);
         end
      end
   endtask
   initial begin
      repeat (4) @(negedge clock_in);
      arst_n_in = 1;
      run(3'h0, 0, 4'h1, 11'h001, 0, 0);
      run(3'h0, 1, 4'h1, 11'h001, 1, 1);
      run(3'h0, 1, 4'h3, 11'h002, 1, 0);
      run(3'h0, 1, 4'h0, 11'h002, 1, 1);
      run(3'h1, 1, 4'h1, 11'h004, 1, 1);
      run(3'h1, 1, 4'h0, 11'h001, 1, 0);
      run(3'h2, 1, 4'h4, 11'h010, 1, 0);
      run(3'h2, 1, 4'h0, 11'h020, 1, 1);
      run(3'h2, 1, 4'h0, 11'h200, 1, 0);
      run(3'h2, 1, 4'h0, 11'h300, 1, 1);
      run(3'h3, 1, 4'h4, 11'h010, 1, 1);
      run(3'h3, 1, 4'h0, 11'h010, 1, 0);
      run(3'h6, 1, 4'h8, 11'h400, 1, 1);
      run(3'h7, 1, 4'hC, 11'h0C0, 1, 1);
      run(3'h7, 1, 4'h4, 11'h400, 0, 0);
      run(3'h4, 1, 4'h8, 11'h400, 0, 0);
      run(3'h5, 1, 4'h8, 11'h400, 0, 0);
      results;
   end
   initial begin
      #100000;
      err_count++;
      results;
   end
endmodule
bind smc_sleep_ctrl smc_sleep_monitor mon (.*);
`default_nettype wire
